/* scd_defs.svh */
// Offsets, field positions and reset values of the clock generator
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCD_ADR_RCW 8'h00
`define SCD_ADR_LBCFG 8'h04
`define SCD_ADR_UNIT 8'h08
`define SCD_ADR_STAT 8'h0c

// ----------------------------------------------------------------
// Reset configuration word low layout
// ----------------------------------------------------------------
`define SCD_RCW_LOCAL_BUS_CLOCK_MODE_BIT 31
`define SCD_RCW_SPMUL_LSB 24
`define SCD_RCW_CPMUL_LSB 16
`define SCD_HARD_RCW 32'h0402_0000
`define SCD_SPMUL_MIN 4'h2
`define SCD_SPMUL_MAX 4'h5

// ----------------------------------------------------------------
// Unit clocks and local bus divider
// ----------------------------------------------------------------
`define SCD_NUM_UNITS 6
`define SCD_PCIE_IDX 3
`define SCD_UNIT_RST 12'h557
`define SCD_LBDIV_RST 2'h0
`define SCD_LOCK_EDGES 2'h2

`endif

/* scd_pkg.sv */
// Types shared by the clock generator modules
package scd_pkg;

	typedef enum logic [1:0] {
		SCD_RATIO_OFF = 2'h0,
		SCD_RATIO_FULL = 2'h1,
		SCD_RATIO_HALF = 2'h2,
		SCD_RATIO_THIRD = 2'h3
	} scd_ratio_t;

	typedef enum logic [1:0] {
		SCD_LBDIV_2 = 2'h0,
		SCD_LBDIV_4 = 2'h1,
		SCD_LBDIV_8 = 2'h2
	} scd_lbdiv_t;

endpackage: scd_pkg

/* scd_rate_if.sv */
// Carrier between the top and one fractional rate generator
`timescale 1ns/1ns
`default_nettype none

interface scd_rate_if;
	logic enable;
	logic [15:0] period;
	logic [7:0] step;
	logic level;
	logic rise;
	logic toggle;

	modport gen (
		input enable,
		input period,
		input step,
		output level,
		output rise,
		output toggle
	);

	modport user (
		output enable,
		output period,
		output step,
		input level,
		input rise,
		input toggle
	);
endinterface: scd_rate_if

`default_nettype wire

/* scd_rate_gen.sv */
// Fractional rate generator: toggles step times per reference period
`timescale 1ns/1ns
`default_nettype none

module scd_rate_gen
	import scd_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	scd_rate_if.gen rate
);

	logic [16:0] acc;
	logic [16:0] next_acc;
	logic [16:0] diff;

	always_comb begin
		next_acc = acc + {9'h0, rate.step};
		diff = next_acc - {1'b0, rate.period};
	end

	// Output rate is step/period toggles per clock; saturates at one
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !rate.enable) begin
			acc <= 17'h0;
			rate.level <= 1'b0;
			rate.rise <= 1'b0;
			rate.toggle <= 1'b0;
		end else if (next_acc >= {1'b0, rate.period}) begin
			acc <= (diff >= {1'b0, rate.period}) ? 17'h0 : diff;
			rate.level <= ~rate.level;
			rate.rise <= ~rate.level;
			rate.toggle <= 1'b1;
		end else begin
			acc <= next_acc;
			rate.rise <= 1'b0;
			rate.toggle <= 1'b0;
		end
	end

endmodule: scd_rate_gen

`default_nettype wire

/* scd_clock_gen.sv */
// System clock domain generator with Wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "scd_defs.svh"

// Operation
// RL1: System bus clock is input times multiplier
// RL2: Multipliers come from reset config word low
// RL3: Processor clock multiplies system bus clock
// RL4: Memory controller clock is twice bus clock
// RL5: Memory bus clock is controller clock halved
// RL6: Local bus controller clock one or two times
// RL7: Local bus clock through programmable divider
// RL8: Local bus divider selects two, four, eight
// RL9: Unit clocks start at their default ratios
// RL10: Units off, full, half, third; PCIe off/full
// RL11: Software sets unit ratio before access
// RL12: Software keeps clocks within frequency limits
// RL13: Multiplier codes two to five; rest reserved
// RL14: Unit clock switched off stays static
module scd_clock_gen
	import scd_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic primary_clock_input_in,
	input wire logic [31:0] reset_config_word_low_in,
	input wire logic use_hard_config_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic csb_clk_out,
	output logic core_clk_out,
	output logic ddr_clk_out,
	output logic lbc_clk_out,
	output logic memory_bus_clock_out,
	output logic memory_bus_clock_n_out,
	output logic [2:0] local_bus_clock_outputs_out,
	output logic local_bus_sync_output_out,
	output logic [5:0] unit_clk_out
);

	// ----------------------------------------------------------------
	// Reset configuration word
	// ----------------------------------------------------------------
	logic [31:0] reset_config_word_low;
	logic [3:0] system_pll_multiplier;
	logic [3:0] processor_pll_multiplier;
	logic local_bus_clock_mode;
	logic spmul_ok;

	// Loaded only while reset is held, frozen afterwards
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reset_config_word_low <= use_hard_config_in ?
				`SCD_HARD_RCW : reset_config_word_low_in; // RL2
		end
	end

	always_comb begin
		system_pll_multiplier =
			reset_config_word_low[`SCD_RCW_SPMUL_LSB +: 4]; // RL2
		processor_pll_multiplier =
			reset_config_word_low[`SCD_RCW_CPMUL_LSB +: 4]; // RL2
		local_bus_clock_mode = reset_config_word_low[`SCD_RCW_LOCAL_BUS_CLOCK_MODE_BIT];
		spmul_ok = (system_pll_multiplier >= `SCD_SPMUL_MIN) &&
			(system_pll_multiplier <= `SCD_SPMUL_MAX); // RL13
	end

	// ----------------------------------------------------------------
	// Reference period measurement
	// ----------------------------------------------------------------
	logic ref_d;
	logic ref_rise;
	logic [15:0] ref_cnt;
	logic [15:0] ref_period;
	logic [1:0] ref_edges;
	logic locked;

	assign ref_rise = primary_clock_input_in && !ref_d;
	assign locked = (ref_edges == `SCD_LOCK_EDGES);

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ref_d <= 1'b0;
		end else begin
			ref_d <= primary_clock_input_in;
		end
	end

	// Period is the count of clk_in cycles between reference rises
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ref_cnt <= 16'h0;
			ref_period <= 16'h0;
			ref_edges <= 2'h0;
		end else if (ref_rise) begin
			ref_cnt <= 16'h1;
			ref_period <= ref_cnt;
			if (!locked) begin
				ref_edges <= ref_edges + 2'h1;
			end
		end else if (ref_cnt != 16'hffff) begin
			ref_cnt <= ref_cnt + 16'h1;
		end
	end

	// ----------------------------------------------------------------
	// Derived domains: 0 system bus, 1 core, 2 memory ctl, 3 local bus
	// ----------------------------------------------------------------
	logic [7:0] csb_step;
	logic [7:0] core_step;
	logic [7:0] ddr_step;
	logic [7:0] lbc_step;
	logic [7:0] steps [4];
	scd_rate_if rif [4] ();

	always_comb begin
		// Two toggles per output period
		csb_step = {3'h0, system_pll_multiplier, 1'b0}; // RL1
		core_step = 8'(csb_step * {4'h0, processor_pll_multiplier}); // RL3
		ddr_step = {2'h0, system_pll_multiplier, 2'h0}; // RL4
		lbc_step = local_bus_clock_mode ? ddr_step : csb_step; // RL6
		steps[0] = csb_step;
		steps[1] = core_step;
		steps[2] = ddr_step;
		steps[3] = lbc_step;
	end

	for (genvar g = 0; g < 4; g++) begin : g_rate
		// Reserved multiplier keeps every domain stopped
		assign rif[g].enable = locked && spmul_ok; // RL13
		assign rif[g].period = ref_period;
		assign rif[g].step = steps[g];
		scd_rate_gen u_rate (
			.clk_in(clk_in),
			.sys_rst_in(sys_rst_in),
			.rate(rif[g])
		);
	end

	// ----------------------------------------------------------------
	// Memory bus clock pair
	// ----------------------------------------------------------------
	logic mem_clk;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mem_clk <= 1'b0;
		end else if (rif[2].rise) begin
			mem_clk <= ~mem_clk; // RL5
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic bus_req;
	logic wr_lbcfg;
	logic wr_unit;
	logic [7:0] adr_word;

	assign bus_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign adr_word = {wb_adr_in[7:2], 2'b00};
	assign wr_lbcfg = bus_req && wb_we_in && wb_sel_in[0] &&
		(adr_word == `SCD_ADR_LBCFG);
	assign wr_unit = bus_req && wb_we_in && (adr_word == `SCD_ADR_UNIT);

	// ----------------------------------------------------------------
	// Local bus divider
	// ----------------------------------------------------------------
	scd_lbdiv_t local_bus_divider_select;
	scd_lbdiv_t lb_div_act;
	logic [1:0] lb_cnt;
	logic [1:0] lb_last;
	logic lb_clk;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			local_bus_divider_select <= scd_lbdiv_t'(`SCD_LBDIV_RST);
		end else if (wr_lbcfg && wb_dat_in[1:0] != 2'h3) begin
			// Reserved code 3 leaves the divider unchanged
			local_bus_divider_select <= scd_lbdiv_t'(wb_dat_in[1:0]); // RL8
		end
	end

	always_comb begin
		unique case (lb_div_act)
			SCD_LBDIV_2: lb_last = 2'h0;
			SCD_LBDIV_4: lb_last = 2'h1;
			SCD_LBDIV_8: lb_last = 2'h3;
			default: lb_last = 2'h0;
		endcase
	end

	// New divide takes effect only at the end of a whole period
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lb_div_act <= scd_lbdiv_t'(`SCD_LBDIV_RST);
			lb_cnt <= 2'h0;
			lb_clk <= 1'b0;
		end else if (rif[3].rise) begin
			if (lb_cnt == lb_last) begin
				lb_cnt <= 2'h0;
				lb_clk <= ~lb_clk; // RL7
				if (lb_clk) begin
					lb_div_act <= local_bus_divider_select; // RL8
				end
			end else begin
				lb_cnt <= lb_cnt + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configurable unit clocks
	// ----------------------------------------------------------------
	scd_ratio_t unit_req [`SCD_NUM_UNITS];
	scd_ratio_t unit_act [`SCD_NUM_UNITS];
	logic [2:0] unit_cnt [`SCD_NUM_UNITS];
	logic unit_clk [`SCD_NUM_UNITS];
	logic [11:0] unit_req_bits;
	logic [11:0] unit_act_bits;

	// Counts both edges of the system bus clock: last index 2N-1 for ratio 1/N
	function automatic logic [2:0] ratio_last(input scd_ratio_t r);
		unique case (r)
			SCD_RATIO_FULL: ratio_last = 3'h1;
			SCD_RATIO_HALF: ratio_last = 3'h3;
			SCD_RATIO_THIRD: ratio_last = 3'h5;
			default: ratio_last = 3'h0;
		endcase
	endfunction: ratio_last

	function automatic logic [2:0] ratio_half(input scd_ratio_t r);
		unique case (r)
			SCD_RATIO_FULL: ratio_half = 3'h1;
			SCD_RATIO_HALF: ratio_half = 3'h2;
			SCD_RATIO_THIRD: ratio_half = 3'h3;
			default: ratio_half = 3'h0;
		endcase
	endfunction: ratio_half

	for (genvar u = 0; u < `SCD_NUM_UNITS; u++) begin : g_unit
		localparam logic [11:0] RST_BITS = `SCD_UNIT_RST;
		logic [1:0] wr_code;
		logic wr_ok;
		logic [2:0] next_cnt;

		assign wr_code = wb_dat_in[2*u +: 2];
		// Peripheral-express unit accepts only off or full rate
		assign wr_ok = (u != `SCD_PCIE_IDX) ||
			(wr_code == SCD_RATIO_OFF) || (wr_code == SCD_RATIO_FULL); // RL10
		assign next_cnt = (unit_cnt[u] == ratio_last(unit_act[u])) ?
			3'h0 : unit_cnt[u] + 3'h1;
		assign unit_req_bits[2*u +: 2] = unit_req[u];
		assign unit_act_bits[2*u +: 2] = unit_act[u];

		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				unit_req[u] <= scd_ratio_t'(RST_BITS[2*u +: 2]); // RL9
			end else if (wr_unit && wb_sel_in[u/4] && wr_ok) begin
				unit_req[u] <= scd_ratio_t'(wr_code); // RL10
			end
		end

		// Ratio changes only at a period boundary, so no runt pulses
		always_ff @(posedge clk_in) begin
			if (sys_rst_in) begin
				unit_act[u] <= scd_ratio_t'(RST_BITS[2*u +: 2]); // RL9
				unit_cnt[u] <= 3'h0;
				unit_clk[u] <= 1'b0;
			end else if (unit_act[u] == SCD_RATIO_OFF) begin
				unit_clk[u] <= 1'b0; // RL14
				unit_cnt[u] <= 3'h0;
				unit_act[u] <= unit_req[u];
			end else if (rif[0].toggle) begin
				unit_cnt[u] <= next_cnt;
				if (next_cnt == 3'h0) begin
					unit_act[u] <= unit_req[u]; // RL10
					// Low at a boundary, so going off holds it low
					unit_clk[u] <= (unit_req[u] != SCD_RATIO_OFF); // RL14
				end else begin
					unit_clk[u] <= (next_cnt < ratio_half(unit_act[u]));
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus answer and read data
	// ----------------------------------------------------------------
	logic [31:0] rd_data;

	always_comb begin
		unique case (adr_word)
			`SCD_ADR_RCW: rd_data = reset_config_word_low;
			`SCD_ADR_LBCFG: rd_data = {30'h0, local_bus_divider_select};
			`SCD_ADR_UNIT: rd_data = {4'h0, unit_act_bits,
				4'h0, unit_req_bits};
			`SCD_ADR_STAT: rd_data = {ref_period, 14'h0, !spmul_ok, locked};
			default: rd_data = 32'h0;
		endcase
	end

	// One wait state: ack the cycle after the strobe, then drop it
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0;
		end else begin
			wb_ack_out <= bus_req;
			if (bus_req && !wb_we_in) begin
				wb_dat_out <= rd_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registered clock outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			csb_clk_out <= 1'b0;
			core_clk_out <= 1'b0;
			ddr_clk_out <= 1'b0;
			lbc_clk_out <= 1'b0;
			memory_bus_clock_out <= 1'b0;
			memory_bus_clock_n_out <= 1'b0;
			local_bus_clock_outputs_out <= 3'h0;
			local_bus_sync_output_out <= 1'b0;
			unit_clk_out <= 6'h0;
		end else begin
			csb_clk_out <= rif[0].level; // RL1
			core_clk_out <= rif[1].level; // RL3
			ddr_clk_out <= rif[2].level; // RL4
			lbc_clk_out <= rif[3].level; // RL6
			memory_bus_clock_out <= mem_clk; // RL5
			memory_bus_clock_n_out <= !mem_clk && rif[2].enable; // RL5
			local_bus_clock_outputs_out <= {3{lb_clk}}; // RL7
			local_bus_sync_output_out <= lb_clk; // RL7
			for (int i = 0; i < `SCD_NUM_UNITS; i++) begin
				unit_clk_out[i] <= unit_clk[i];
			end
		end
	end

endmodule: scd_clock_gen

`default_nettype wire

/* scd_ref_osc.sv */
// Free-running reference oscillator standing in for the board source
`timescale 1ns/1ns
`default_nettype none

module scd_ref_osc (
	input wire logic clk_in,
	input wire logic [15:0] half_in,
	output logic ref_out
);
	// --------
	// Square wave
	// --------
	logic [15:0] cnt;

	initial begin
		cnt = 16'h0;
		ref_out = 1'b0;
	end

	// Slow source, so the fastest derived clock stays within limits
	always @(posedge clk_in) begin
		if (cnt >= half_in - 16'h1) begin
			cnt <= 16'h0;
			ref_out <= ~ref_out;
		end else begin
			cnt <= cnt + 16'h1;
		end
	end
endmodule: scd_ref_osc

`default_nettype wire

/* scd_clock_gen_chk.sv */
// Port-level checks on the clock generator
`timescale 1ns/1ns
`default_nettype none
`include "scd_defs.svh"

module scd_clock_gen_chk (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [31:0] reset_config_word_low_in,
	input wire logic use_hard_config_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic csb_clk_out,
	input wire logic core_clk_out,
	input wire logic ddr_clk_out,
	input wire logic lbc_clk_out,
	input wire logic memory_bus_clock_out,
	input wire logic memory_bus_clock_n_out,
	input wire logic [2:0] local_bus_clock_outputs_out,
	input wire logic local_bus_sync_output_out,
	input wire logic [5:0] unit_clk_out
);
	// --------
	// Word latched on the last reset edge
	// --------
	logic [31:0] cfg;
	logic rsv;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cfg <= use_hard_config_in ? `SCD_HARD_RCW : reset_config_word_low_in;
		end
	end
	assign rsv = !(cfg[27:24] inside {[`SCD_SPMUL_MIN:`SCD_SPMUL_MAX]});

	// --------
	// Assertions
	// --------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence rd_q;
		wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out;
	endsequence

	AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held too long");
	AST_ACK_REQ: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|=> wb_ack_out) else $error("request not answered");
	AST_RST_LOW: assert property (disable iff (1'b0) sys_rst_in |=>
		!csb_clk_out && !wb_ack_out && unit_clk_out == 6'h0)
		else $error("output active after reset");
	AST_RCW_READ: assert property (rd_q ##0 wb_adr_in[7:2] == 6'h0 |=>
		(wb_dat_out & 32'h8f0f_0000) == (cfg & 32'h8f0f_0000))
		else $error("config word read wrong");
	AST_RSV_STOP: assert property (rsv |->
		!csb_clk_out && !core_clk_out && !ddr_clk_out)
		else $error("clock runs on reserved multiplier");
	AST_LBC_ONE: assert property (!cfg[31] |-> lbc_clk_out == csb_clk_out)
		else $error("local bus clock not at bus rate");
	AST_MB_PAIR: assert property (memory_bus_clock_n_out |->
		!memory_bus_clock_out) else $error("memory clock pair both high");
	AST_LB_SAME: assert property (local_bus_clock_outputs_out ==
		{3{local_bus_sync_output_out}}) else $error("local bus outputs differ");
	AST_LB_RATE: assert property ($changed(local_bus_sync_output_out) |=>
		$stable(local_bus_sync_output_out))
		else $error("local bus clock too fast");
endmodule: scd_clock_gen_chk

bind scd_clock_gen scd_clock_gen_chk chk (.*);

`default_nettype wire

/* system_clock_domain_generation_bench.sv */
// Self-checking bench for the clock generator
`timescale 1ns/1ns
`default_nettype none
`include "scd_defs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
	$display("wrong value at %0t: got %h want %h", $time, a, e); end end

module system_clock_domain_generation_bench
	import scd_pkg::*;
;
	// --------
	// Design and partner
	// --------
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic primary_clock_input_in;
	logic [31:0] reset_config_word_low_in = 32'h0;
	logic use_hard_config_in = 1'b0;
	logic wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0;
	logic [7:0] wb_adr_in = 8'h0;
	logic [3:0] wb_sel_in = 4'hf;
	logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
	logic wb_ack_out, csb_clk_out, core_clk_out, ddr_clk_out, lbc_clk_out;
	logic memory_bus_clock_out, memory_bus_clock_n_out;
	logic local_bus_sync_output_out;
	logic [2:0] local_bus_clock_outputs_out;
	logic [5:0] unit_clk_out;
	logic [15:0] half = 16'h64;
	logic [11:0] obs, prv;
	logic cen = 1'b0;
	int cnt [12];
	int fails = 0, n_compared = 0;

	always #20 clk_in = ~clk_in;

	scd_clock_gen dut (.*);
	scd_ref_osc osc (.clk_in(clk_in), .half_in(half),
		.ref_out(primary_clock_input_in));

	// Toggle counts over eight reference periods give the rate of every clock but memory_bus_clock_n_out, local_bus_sync_output_out and local bus outputs 2:1
	assign obs = {unit_clk_out, local_bus_clock_outputs_out[0],
		memory_bus_clock_out, lbc_clk_out, ddr_clk_out, core_clk_out, csb_clk_out};
	always @(posedge clk_in) begin
		prv <= obs;
		if (cen) foreach (cnt[i]) cnt[i] += int'(obs[i] ^ prv[i]);
	end

	// --------
	// Helpers
	// --------
	function automatic int near(int a, int e);
		return (a - e <= 2) && (e - a <= 2);
	endfunction: near

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= w;
		wb_adr_in <= a;
		wb_dat_in <= d;
		t = 0;
		do begin
			@(posedge clk_in);
			t++;
		end while (wb_ack_out !== 1'b1 && t < 50);
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
		if (t >= 50) begin
			fails++;
			$display("wrong value at %0t: no bus answer", $time);
		end
	endtask: wb

	task automatic run(input logic h, input logic [3:0] s, input logic [3:0] c,
		input logic m, input logic [1:0] dv, input logic [11:0] u);
		logic [31:0] q, w;
		logic [11:0] ux;
		logic [1:0] dx;
		int p, se, lm, e;
		w = h ? `SCD_HARD_RCW : {m, 3'h0, s, 4'h0, c, 16'h0};
		se = (w[27:24] inside {[4'h2:4'h5]}) ? int'(w[27:24]) : 0;
		lm = w[31] ? 2 : 1;
		dx = (dv == 2'h3) ? SCD_LBDIV_2 : dv;
		ux = (u[7:6] > SCD_RATIO_FULL) ? {u[11:8], SCD_RATIO_FULL, u[5:0]} : u;
		@(posedge clk_in);
		half <= 16'h50 + 16'h14 * 16'($urandom % 2);
		sys_rst_in <= 1'b1;
		use_hard_config_in <= h;
		reset_config_word_low_in <= h ? $urandom : w;
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		p = 2 * half;
		repeat (3 * p) @(posedge clk_in);
		wb(1'b1, `SCD_ADR_RCW, ~w, q);
		wb(1'b0, `SCD_ADR_RCW, 32'h0, q);
		`CHK(q & 32'h8f0f_0000, w & 32'h8f0f_0000)
		wb(1'b0, `SCD_ADR_STAT, 32'h0, q);
		`CHK(q[1], 1'(se == 0))
		`CHK(q[31:16], 16'(p))
		wb(1'b0, `SCD_ADR_UNIT, 32'h0, q);
		`CHK({q[27:16], q[11:0]}, {2{`SCD_UNIT_RST}})
		wb(1'b1, `SCD_ADR_LBCFG, {30'h0, dv}, q);
		wb(1'b1, `SCD_ADR_UNIT, {20'h0, u}, q);
		wb(1'b1, 8'h40, $urandom, q);
		wb(1'b0, 8'h40, 32'h0, q);
		`CHK(q, 32'h0)
		wb(1'b0, `SCD_ADR_LBCFG, 32'h0, q);
		`CHK(q[1:0], dx)
		repeat (2 * p) @(posedge clk_in);
		wb(1'b0, `SCD_ADR_UNIT, 32'h0, q);
		if (se != 0) `CHK(q[27:16], ux)
		foreach (cnt[i]) cnt[i] = 0;
		cen <= 1'b1;
		repeat (8 * p) @(posedge clk_in);
		cen <= 1'b0;
		@(posedge clk_in);
		`CHK(near(cnt[0], 16 * se), 1)
		`CHK(near(cnt[1], 16 * se * int'(w[19:16])), 1)
		`CHK(near(cnt[2], 32 * se), 1)
		`CHK(near(cnt[3], 16 * se * lm), 1)
		`CHK(near(cnt[4], 16 * se), 1)
		`CHK(near(cnt[5], 16 * se * lm / (2 << dx)), 1)
		for (int i = 0; i < 6; i++) begin
			e = int'(ux[2 * i +: 2]);
			`CHK(near(cnt[6 + i], e == 0 ? 0 : 16 * se / e), 1)
			if (e == 0) `CHK(unit_clk_out[i], 1'b0)
		end
		$display("test done: word %h divider %0d units %h", w, dv, u);
	endtask: run

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask: finish_test

	// --------
	// Sequence and watchdog
	// --------
	initial begin
		void'($urandom(57));
		run(1'b1, 4'h0, 4'h0, 1'b0, 2'h1, 12'h557);
		run(1'b0, 4'h0, 4'h1, 1'b0, 2'h0, 12'h557);
		run(1'b0, 4'h1, 4'h1, 1'b0, 2'h0, 12'h557);
		run(1'b0, 4'h6, 4'h1, 1'b1, 2'h0, 12'h557);
		run(1'b0, 4'hf, 4'h1, 1'b0, 2'h0, 12'h557);
		run(1'b0, 4'h5, 4'h3, 1'b1, 2'h2, 12'hfff);
		run(1'b0, 4'h2, 4'h0, 1'b1, 2'h3, 12'h9b4);
		repeat (5) run(1'b0, 4'h2 + 4'($urandom % 4), 4'($urandom % 4),
			1'($urandom), 2'($urandom), 12'($urandom));
		finish_test;
	end

	// Generous bound: each configuration needs under 3000 cycles
	initial begin
		repeat (60000) @(posedge clk_in);
		fails++;
		finish_test;
	end
endmodule: system_clock_domain_generation_bench

`default_nettype wire
